// file: hdl/esri_pkg.sv
package esri_pkg;
   // Register word addresses
   localparam logic [3:0] ADDR_FUNC_CFG = 4'h0;
   localparam logic [3:0] ADDR_IN_FN0 = 4'h1;
   localparam logic [3:0] ADDR_ROUTE0 = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'hB;
   localparam logic [3:0] ADDR_MASK = 4'hC;
   localparam logic [3:0] ADDR_STATE = 4'hD;
   localparam logic [3:0] ADDR_REMAIN = 4'hE;
   localparam logic [3:0] ADDR_CONTROL = 4'hF;
   // Function configuration fields
   localparam int CFG_PULSE80 = 0;
   localparam int CFG_LATCH = 1;
   localparam int CFG_INHIB_ROUTE = 7;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Input function fields
   localparam int INF_ESTART = 0;
   localparam int INF_EXT_INHIB = 1;
   localparam int INF_EXT_TRIP = 2;
   // Routing source bits: protection trips, then start-up, then ext trip
   localparam int N_PROT = 8;
   localparam int SRC_MSTART = 8;
   localparam int SRC_EXT_TRIP = 9;
   localparam int N_SRC = 10;
   localparam logic [N_SRC-1:0] ROUTE_TRIP_RESET = 10'h0FF;
   // Status / mask bits
   localparam int ST_ESTART = 0;
   localparam int ST_INHIB = 1;
   localparam int ST_TRIP = 2;
   // Counts
   localparam int CTRL_CLR_LATCH = 0;
   localparam int N_DI = 5;
   localparam int N_OUT = 5;
   localparam int N_TRIP = 3;
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_HZ = 1_000;
   localparam int TICK_CYC = CLK_HZ / TICK_HZ;
   localparam int ESTART_MIN = 10;
   localparam int ESTART_MS = ESTART_MIN * 60 * 1000;
   localparam int PULSE_SHORT_MS = 40;
   localparam int PULSE_LONG_MS = 80;
   localparam logic [15:0] THERM_MARGIN = 16'h0001;
   localparam logic [15:0] CNT_MARGIN = 16'h0001;
   localparam int TEMP_RAISE_DIV = 10;
   typedef enum logic [1:0] {
      ESRI_ES_IDLE = 2'b00,
      ESRI_ES_RUN = 2'b01,
      ESRI_ES_HOLD = 2'b10
   } esri_es_e;
endpackage

// file: hdl/esri_top.sv
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module esri_top #(
   parameter int TICK_CYCLES = esri_pkg::TICK_CYC,
   parameter int ESTART_TICKS = esri_pkg::ESTART_MS
) (
   input wire logic clk_sys_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [3:0] addr_i, // Register word address
   input wire logic [15:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [15:0] rdata_o, // Read data, cycle after strobe
   input wire logic [esri_pkg::N_DI-1:0] di_i, // Digital input pins
   input wire logic [esri_pkg::N_PROT-1:0] prot_trip_i, // Element trips
   input wire logic therm_inhib_i, // Thermal element inhibit
   input wire logic cnt_inhib_i, // Start-time counter inhibit
   input wire logic motor_start_i, // Motor start-up signal
   input wire logic [15:0] therm_limit_i, // Thermal inhibit level
   input wire logic [15:0] cnt_limit_i, // Counter inhibit value
   input wire logic [15:0] temp_a_set_i, // Temperature A trip set
   input wire logic [15:0] temp_b_set_i, // Temperature B trip set
   input wire logic [15:0] therm_rem_i, // Thermal time to restart
   input wire logic [15:0] cnt_rem_i, // Counter time to restart
   output logic trip_out_a_o, // Trip contact A
   output logic trip_out_b_o, // Trip contact B
   output logic trip_out_c_o, // Trip contact C
   output logic signal_out_a_o, // Signal contact A
   output logic signal_out_b_o, // Signal contact B
   output logic restart_inhib_o, // Restart inhibit level
   output logic estart_act_o, // Emergency start active
   output logic therm_preset_o, // Pulse: load thermal level
   output logic [15:0] therm_preset_val_o, // Thermal level to load
   output logic cnt_preset_o, // Pulse: load start-time counter
   output logic [15:0] cnt_preset_val_o, // Counter value to load
   output logic [16:0] temp_a_thr_o, // Effective temperature A trip
   output logic [16:0] temp_b_thr_o, // Effective temperature B trip
   output logic estart_event_o, // Pulse: emergency start event
   output logic irq_o // Interrupt, level
);
   import esri_pkg::*;

   localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);
   localparam logic [19:0] ES_LAST = 20'(ESTART_TICKS - 1);
   localparam logic [6:0] P_SHORT = 7'(PULSE_SHORT_MS);
   localparam logic [6:0] P_LONG = 7'(PULSE_LONG_MS);

   typedef struct packed {
      logic [N_DI-1:0] di_s1;
      logic [N_DI-1:0] di_s2;
      logic [13:0] pre;
      logic tick;
      esri_es_e es_state;
      logic [19:0] es_cnt;
      logic es_act;
      logic therm_pre;
      logic [15:0] therm_val;
      logic cnt_pre;
      logic [15:0] cnt_val;
      logic es_evt;
      logic [16:0] temp_a;
      logic [16:0] temp_b;
      logic [7:0] cfg;
      logic [N_DI-1:0][2:0] infn;
      logic [N_OUT-1:0][N_SRC-1:0] route;
      logic [N_OUT-1:0][6:0] pcnt;
      logic [N_OUT-1:0] src_d;
      logic [N_TRIP-1:0] latch;
      logic [N_OUT-1:0] outs;
      logic inhib;
      logic [2:0] stat;
      logic [2:0] mask;
      logic [15:0] remain;
      logic [15:0] rdata;
      logic irq;
   } esri_state_s;

   esri_state_s st_r;
   esri_state_s st_nxt;

   function automatic logic [16:0] esri_raise(input logic [15:0] v,
                                               input logic en);
      logic [16:0] r;
      r = {1'b0, v};
      if (en) begin
         r = r + 17'(v / 16'(TEMP_RAISE_DIV));
      end
      return r;
   endfunction

   function automatic logic [15:0] esri_below(input logic [15:0] lim,
                                              input logic [15:0] m);
      return (lim > m) ? lim - m : 16'h0000;
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic es_in;
      logic ext_inhib;
      logic ext_trip;
      logic any_trip;
      logic inh;
      logic [N_SRC-1:0] src;
      logic [N_OUT-1:0] want;
      logic [N_OUT-1:0] drv;
      logic [6:0] plen;
      logic [2:0] ev;
      logic [N_TRIP-1:0] lset;
      es_in = 1'b0;
      ext_inhib = 1'b0;
      ext_trip = 1'b0;
      any_trip = 1'b0;
      inh = 1'b0;
      src = '0;
      want = '0;
      drv = '0;
      plen = '0;
      ev = '0;
      lset = '0;
      st_nxt = st_r;

      st_nxt.di_s1 = di_i;
      st_nxt.di_s2 = st_r.di_s1;

      // Input functions per digital input
      for (int i = 0; i < N_DI; i++) begin
         es_in = es_in | (st_r.di_s2[i] & st_r.infn[i][INF_ESTART]);
         ext_inhib = ext_inhib |
                     (st_r.di_s2[i] & st_r.infn[i][INF_EXT_INHIB]);
         ext_trip = ext_trip | (st_r.di_s2[i] & st_r.infn[i][INF_EXT_TRIP]);
      end

      // Millisecond tick prescaler
      st_nxt.tick = 1'b0;
      if (st_r.pre == TICK_LAST) begin
         st_nxt.pre = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.pre = st_r.pre + 14'h0001;
      end

      // ---------------------------------------------------------------
      // Emergency start sequencer
      // ---------------------------------------------------------------
      st_nxt.therm_pre = 1'b0;
      st_nxt.cnt_pre = 1'b0;
      st_nxt.es_evt = 1'b0;
      unique case (st_r.es_state)
         ESRI_ES_IDLE: begin
            if (es_in) begin
               st_nxt.es_state = ESRI_ES_RUN;
               st_nxt.es_cnt = '0;
               st_nxt.therm_pre = 1'b1;
               st_nxt.therm_val = esri_below(therm_limit_i, THERM_MARGIN);
               st_nxt.cnt_pre = 1'b1;
               st_nxt.cnt_val = esri_below(cnt_limit_i, CNT_MARGIN);
               st_nxt.es_evt = 1'b1;
            end
         end
         ESRI_ES_RUN: begin
            if (st_r.tick) begin
               if (st_r.es_cnt == ES_LAST) begin
                  st_nxt.es_state = es_in ? ESRI_ES_HOLD : ESRI_ES_IDLE;
               end else begin
                  st_nxt.es_cnt = st_r.es_cnt + 20'h00001;
               end
            end
         end
         ESRI_ES_HOLD: begin
            if (!es_in) begin
               st_nxt.es_state = ESRI_ES_IDLE;
            end
         end
         default: begin
            st_nxt.es_state = ESRI_ES_IDLE;
         end
      endcase
      st_nxt.es_act = (st_nxt.es_state == ESRI_ES_RUN);

      st_nxt.temp_a = esri_raise(temp_a_set_i, st_r.es_act);
      st_nxt.temp_b = esri_raise(temp_b_set_i, st_r.es_act);

      // ---------------------------------------------------------------
      // Restart inhibit
      // ---------------------------------------------------------------
      any_trip = |prot_trip_i;
      inh = any_trip | therm_inhib_i | cnt_inhib_i |
            (ext_inhib & ~st_r.es_act);
      st_nxt.inhib = inh;
      st_nxt.remain = !st_r.inhib ? 16'h0000 :
                      (therm_rem_i > cnt_rem_i) ? therm_rem_i : cnt_rem_i;

      // ---------------------------------------------------------------
      // Output routing, minimum pulse, latching
      // ---------------------------------------------------------------
      src = '0;
      src[N_PROT-1:0] = prot_trip_i;
      src[SRC_MSTART] = motor_start_i;
      src[SRC_EXT_TRIP] = ext_trip;
      for (int o = 0; o < N_OUT; o++) begin
         want[o] = |(src & st_r.route[o]);
      end
      if (!st_r.cfg[CFG_INHIB_ROUTE]) begin
         want[N_TRIP-1] = st_r.inhib;
      end
      plen = st_r.cfg[CFG_PULSE80] ? P_LONG : P_SHORT;
      st_nxt.src_d = want;
      for (int o = 0; o < N_OUT; o++) begin
         if (want[o] && !st_r.src_d[o]) begin
            st_nxt.pcnt[o] = plen;
         end else if (st_r.tick && st_r.pcnt[o] != 7'h00) begin
            st_nxt.pcnt[o] = st_r.pcnt[o] - 7'h01;
         end
         drv[o] = want[o] | (st_r.pcnt[o] != 7'h00);
      end
      for (int t = 0; t < N_TRIP; t++) begin
         lset[t] = st_r.cfg[CFG_LATCH] & drv[t];
         if (lset[t]) begin
            st_nxt.latch[t] = 1'b1;
         end
         drv[t] = drv[t] | st_r.latch[t];
      end
      st_nxt.outs = drv;

      // ---------------------------------------------------------------
      // Register access
      // ---------------------------------------------------------------
      ev[ST_ESTART] = st_r.es_evt;
      ev[ST_INHIB] = st_nxt.inhib & ~st_r.inhib;
      ev[ST_TRIP] = |(drv[N_TRIP-1:0] & ~st_r.outs[N_TRIP-1:0]);
      st_nxt.rdata = '0;
      if (wr_i) begin
         if (addr_i == ADDR_FUNC_CFG) begin
            st_nxt.cfg = wdata_i[7:0];
         end
         if (addr_i == ADDR_STATUS) begin
            st_nxt.stat = st_r.stat & ~wdata_i[2:0];
         end
         if (addr_i == ADDR_MASK) begin
            st_nxt.mask = wdata_i[2:0];
         end
         if (addr_i == ADDR_CONTROL && wdata_i[CTRL_CLR_LATCH]) begin
            // A trip in the clear cycle keeps its latch
            st_nxt.latch = lset;
         end
         for (int i = 0; i < N_DI; i++) begin
            if (addr_i == ADDR_IN_FN0 + 4'(i)) begin
               st_nxt.infn[i] = wdata_i[2:0];
            end
         end
         for (int o = 0; o < N_OUT; o++) begin
            if (addr_i == ADDR_ROUTE0 + 4'(o)) begin
               st_nxt.route[o] = wdata_i[N_SRC-1:0];
            end
         end
      end
      st_nxt.stat = st_nxt.stat | ev;
      if (rd_i) begin
         if (addr_i == ADDR_FUNC_CFG) begin
            st_nxt.rdata = {8'h00, st_r.cfg};
         end
         if (addr_i == ADDR_STATUS) begin
            st_nxt.rdata = {13'h0000, st_r.stat};
         end
         if (addr_i == ADDR_MASK) begin
            st_nxt.rdata = {13'h0000, st_r.mask};
         end
         if (addr_i == ADDR_STATE) begin
            st_nxt.rdata = {4'h0, st_r.latch, st_r.outs, st_r.es_state,
                            st_r.es_act, st_r.inhib};
         end
         if (addr_i == ADDR_REMAIN) begin
            st_nxt.rdata = st_r.remain;
         end
         for (int i = 0; i < N_DI; i++) begin
            if (addr_i == ADDR_IN_FN0 + 4'(i)) begin
               st_nxt.rdata = {13'h0000, st_r.infn[i]};
            end
         end
         for (int o = 0; o < N_OUT; o++) begin
            if (addr_i == ADDR_ROUTE0 + 4'(o)) begin
               st_nxt.rdata = {6'h00, st_r.route[o]};
            end
         end
      end
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
         st_r.es_state <= ESRI_ES_IDLE;
         st_r.cfg <= CFG_RESET;
         for (int o = 0; o < N_TRIP; o++) begin
            st_r.route[o] <= ROUTE_TRIP_RESET;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o = st_r.rdata;
   assign trip_out_a_o = st_r.outs[0];
   assign trip_out_b_o = st_r.outs[1];
   assign trip_out_c_o = st_r.outs[2];
   assign signal_out_a_o = st_r.outs[3];
   assign signal_out_b_o = st_r.outs[4];
   assign restart_inhib_o = st_r.inhib;
   assign estart_act_o = st_r.es_act;
   assign therm_preset_o = st_r.therm_pre;
   assign therm_preset_val_o = st_r.therm_val;
   assign cnt_preset_o = st_r.cnt_pre;
   assign cnt_preset_val_o = st_r.cnt_val;
   assign temp_a_thr_o = st_r.temp_a;
   assign temp_b_thr_o = st_r.temp_b;
   assign estart_event_o = st_r.es_evt;
   assign irq_o = st_r.irq;
endmodule
`default_nettype wire

// file: dv/esri_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module esri_motor_model #(
   parameter int START_CYC = 5
) (
   input wire logic clk_sys_i, // Clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic start_req_i, // Close request
   input wire logic trip_i, // Trip contacts ORed
   output logic motor_start_o // Start-up signal
);
   int cnt_r;
   // Contactor drops out on any trip, ending the start-up
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 0;
      end else if (trip_i) begin
         cnt_r <= 0;
      end else if (start_req_i && cnt_r == 0) begin
         cnt_r <= START_CYC;
      end else if (cnt_r > 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   assign motor_start_o = (cnt_r > 0);
endmodule
`default_nettype wire

// file: dv/esri_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module esri_top_monitor #(
   parameter int TICK_CYCLES = 4,
   parameter int ESTART_TICKS = 20
) (
   input wire logic clk_sys_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic [esri_pkg::N_PROT-1:0] prot_trip_i, // Trips
   input wire logic therm_inhib_i, // Thermal inhibit
   input wire logic cnt_inhib_i, // Counter inhibit
   input wire logic [15:0] therm_limit_i, // Thermal limit
   input wire logic [15:0] cnt_limit_i, // Counter limit
   input wire logic [15:0] temp_a_set_i, // Temp A set
   input wire logic [15:0] temp_b_set_i, // Temp B set
   input wire logic signal_out_a_o, // Signal A
   input wire logic restart_inhib_o, // Inhibit
   input wire logic estart_act_o, // Estart active
   input wire logic therm_preset_o, // Thermal load
   input wire logic [15:0] therm_preset_val_o, // Thermal value
   input wire logic cnt_preset_o, // Counter load
   input wire logic [15:0] cnt_preset_val_o, // Counter value
   input wire logic [16:0] temp_a_thr_o, // Temp A trip
   input wire logic [16:0] temp_b_thr_o, // Temp B trip
   input wire logic estart_event_o // Estart event
);
   import esri_pkg::*;
   localparam int WIN_LO = (ESTART_TICKS - 1) * TICK_CYCLES - 1;
   localparam int WIN_HI = (ESTART_TICKS + 1) * TICK_CYCLES + 1;
   int act_cnt_r;
   logic [16:0] up_a;
   logic [16:0] up_b;
   assign up_a = {1'b0, temp_a_set_i} + 17'(temp_a_set_i / 16'h000A);
   assign up_b = {1'b0, temp_b_set_i} + 17'(temp_b_set_i / 16'h000A);
   // Length of the current emergency start window
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_cnt_r <= 0;
      end else begin
         act_cnt_r <= estart_act_o ? act_cnt_r + 1 : 0;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_inhib;
      (|prot_trip_i || therm_inhib_i || cnt_inhib_i) |=> restart_inhib_o;
   endproperty
   a_inhib: assert property (p_inhib) else $error("inhibit missing");
   property p_temp_up;
      estart_act_o && $past(estart_act_o) && $stable(temp_a_set_i)
         && $stable(temp_b_set_i) |-> temp_a_thr_o == up_a
         && temp_b_thr_o == up_b;
   endproperty
   a_temp_up: assert property (p_temp_up) else $error("temp raise");
   property p_temp_off;
      $past(rst_n_i) && !estart_act_o && !$past(estart_act_o)
         && $stable(temp_a_set_i) && $stable(temp_b_set_i)
         |-> temp_a_thr_o == {1'b0, temp_a_set_i}
         && temp_b_thr_o == {1'b0, temp_b_set_i};
   endproperty
   a_temp_off: assert property (p_temp_off) else $error("temp set");
   property p_start;
      $rose(estart_act_o) |-> therm_preset_o && cnt_preset_o
         && estart_event_o;
   endproperty
   a_start: assert property (p_start) else $error("start pulses");
   property p_event;
      estart_event_o |-> estart_act_o && !$past(estart_act_o);
   endproperty
   a_event: assert property (p_event) else $error("event pulse");
   property p_therm_val;
      therm_preset_o && $past(therm_limit_i) > 16'h0001
         |-> therm_preset_val_o == $past(therm_limit_i) - 16'h0001;
   endproperty
   a_therm_val: assert property (p_therm_val) else $error("therm val");
   property p_cnt_val;
      cnt_preset_o && $past(cnt_limit_i) > 16'h0001
         |-> cnt_preset_val_o == $past(cnt_limit_i) - 16'h0001;
   endproperty
   a_cnt_val: assert property (p_cnt_val) else $error("cnt val");
   property p_window;
      $fell(estart_act_o) |-> act_cnt_r >= WIN_LO && act_cnt_r <= WIN_HI;
   endproperty
   a_window: assert property (p_window) else $error("window");
   property p_min_pulse;
      $rose(signal_out_a_o) |-> signal_out_a_o [*8];
   endproperty
   a_min_pulse: assert property (p_min_pulse) else $error("pulse");
endmodule
bind esri_top esri_top_monitor #(
   .TICK_CYCLES(TICK_CYCLES),
   .ESTART_TICKS(ESTART_TICKS)
) i_esri_top_monitor (
   .clk_sys_i, .rst_n_i, .prot_trip_i, .therm_inhib_i, .cnt_inhib_i,
   .therm_limit_i, .cnt_limit_i, .temp_a_set_i, .temp_b_set_i,
   .signal_out_a_o, .restart_inhib_o, .estart_act_o, .therm_preset_o,
   .therm_preset_val_o, .cnt_preset_o, .cnt_preset_val_o,
   .temp_a_thr_o, .temp_b_thr_o, .estart_event_o
);
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import esri_pkg::*;
   localparam int TK = 4;
   localparam int ET = 20;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o;
   logic [N_DI-1:0] di_i = '0;
   logic [N_PROT-1:0] prot_trip_i = '0;
   logic therm_inhib_i = 1'b0, cnt_inhib_i = 1'b0, start_req = 1'b0;
   logic [15:0] therm_limit_i = 16'h0000, cnt_limit_i = 16'h0000;
   logic [15:0] temp_a_set_i = 16'h0000, temp_b_set_i = 16'h0000;
   logic [15:0] therm_rem_i = 16'h0000, cnt_rem_i = 16'h0000;
   logic motor_start_i, trip_out_a_o, trip_out_b_o, trip_out_c_o;
   logic signal_out_a_o, signal_out_b_o, restart_inhib_o, estart_act_o;
   logic therm_preset_o, cnt_preset_o, estart_event_o, irq_o;
   logic [15:0] therm_preset_val_o, cnt_preset_val_o;
   logic [16:0] temp_a_thr_o, temp_b_thr_o;
   int num_errors = 0, num_checks = 0, cyc = 0, n, t0;
   always #50 clk_sys_i = ~clk_sys_i;
   esri_top #(.TICK_CYCLES(TK), .ESTART_TICKS(ET)) i_esri_top (
      .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .di_i, .prot_trip_i, .therm_inhib_i, .cnt_inhib_i, .motor_start_i,
      .therm_limit_i, .cnt_limit_i, .temp_a_set_i, .temp_b_set_i,
      .therm_rem_i, .cnt_rem_i, .trip_out_a_o, .trip_out_b_o, .trip_out_c_o,
      .signal_out_a_o, .signal_out_b_o, .restart_inhib_o, .estart_act_o,
      .therm_preset_o, .therm_preset_val_o, .cnt_preset_o,
      .cnt_preset_val_o, .temp_a_thr_o, .temp_b_thr_o, .estart_event_o,
      .irq_o
   );
   esri_motor_model i_esri_motor_model (
      .clk_sys_i, .rst_n_i, .start_req_i(start_req),
      .trip_i(trip_out_a_o | trip_out_b_o | trip_out_c_o),
      .motor_start_o(motor_start_i)
   );
   // ----------------------------
   // Tasks
   // ----------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic cyc_n(input int c);
      repeat (c) @(posedge clk_sys_i);
      #10;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [3:0] a,
                      input logic [15:0] e);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #10;
      chk(nm, e, rdata_o);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   // ----------------------------
   // Scenarios
   // ----------------------------
   initial begin
      void'($urandom(49557));
      therm_limit_i <= 16'($urandom_range(65535, 2));
      cnt_limit_i <= 16'($urandom_range(65535, 2));
      temp_a_set_i <= 16'($urandom);
      temp_b_set_i <= 16'($urandom);
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rdc("cfg", ADDR_FUNC_CFG, 16'h0000);
      rdc("route_a", ADDR_ROUTE0, 16'h00FF);
      rdc("route_sa", ADDR_ROUTE0 + 4'h3, 16'h0000);
      wr(ADDR_STATE, 16'hFFFF);
      rdc("state", ADDR_STATE, 16'h0000);
      wr(ADDR_IN_FN0 + 4'h1, 16'h0002);
      for (int i = 0; i < 4; i++) begin
         therm_rem_i <= 16'($urandom);
         cnt_rem_i <= 16'($urandom);
         prot_trip_i <= (i == 0) ? 8'h01 << $urandom_range(7, 0) : 8'h00;
         therm_inhib_i <= (i == 1);
         cnt_inhib_i <= (i == 2);
         di_i[1] <= (i == 3);
         cyc_n(6);
         chk("inhib", 1, restart_inhib_o);
         chk("trip_a", i == 0, trip_out_a_o);
         chk("trip_b", i == 0, trip_out_b_o);
         chk("sig_b", 0, signal_out_b_o);
         chk("trip_c", 1, trip_out_c_o);
         chk("sig_a", 0, signal_out_a_o);
         rdc("remain", ADDR_REMAIN, therm_rem_i > cnt_rem_i ?
             therm_rem_i : cnt_rem_i);
         {prot_trip_i, therm_inhib_i, cnt_inhib_i, di_i[1]} <= '0;
         cyc_n(200);
         chk("idle", 0, {restart_inhib_o, trip_out_a_o, trip_out_c_o});
      end
      wr(ADDR_FUNC_CFG, 16'h0080);
      therm_inhib_i <= 1'b1;
      cyc_n(4);
      chk("trip_c_off", 0, trip_out_c_o);
      chk("inhib_on", 1, restart_inhib_o);
      therm_inhib_i <= 1'b0;
      wr(ADDR_ROUTE0 + 4'h3, 16'h0100);
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_FUNC_CFG, 16'h0080 | 16'(p));
         start_req <= 1'b1;
         cyc_n(1);
         start_req <= 1'b0;
         n = 0;
         repeat (400) begin
            cyc_n(1);
            n += int'(signal_out_a_o);
         end
         chk("pulse", 1, n >= 40 * TK * (p + 1) - TK - 1
             && n <= 40 * TK * (p + 1) + TK + 1);
      end
      wr(ADDR_FUNC_CFG, 16'h0082);
      prot_trip_i <= 8'h01;
      cyc_n(1);
      prot_trip_i <= 8'h00;
      cyc_n(400);
      chk("latched", 1, trip_out_a_o);
      wr(ADDR_CONTROL, 16'h0001);
      cyc_n(3);
      chk("unlatched", 0, trip_out_a_o);
      wr(ADDR_IN_FN0 + 4'h2, 16'h0004);
      wr(ADDR_ROUTE0 + 4'h4, 16'h0200);
      di_i[2] <= 1'b1;
      cyc_n(5);
      chk("ext_trip", 1, signal_out_b_o);
      di_i[2] <= 1'b0;
      wr(ADDR_IN_FN0, 16'h0001);
      wr(ADDR_MASK, 16'h0001);
      wr(ADDR_STATUS, 16'h0007);
      di_i[1] <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         di_i[0] <= 1'b1;
         n = 0;
         do begin
            cyc_n(1);
            n++;
         end while (estart_event_o !== 1'b1 && n < 8);
         t0 = cyc;
         chk("ev_lat", 3, n);
         chk("presets", 2'b11, {therm_preset_o, cnt_preset_o});
         chk("th_val", therm_limit_i - 16'h0001, therm_preset_val_o);
         chk("cn_val", cnt_limit_i - 16'h0001, cnt_preset_val_o);
         cyc_n(2);
         chk("act", 1, estart_act_o);
         chk("temp_a", {1'b0, temp_a_set_i} + temp_a_set_i / 10,
             temp_a_thr_o);
         chk("temp_b", {1'b0, temp_b_set_i} + temp_b_set_i / 10,
             temp_b_thr_o);
         chk("ext_ign", 0, restart_inhib_o);
         chk("irq", s == 0, irq_o);
         if (s == 0) begin
            wr(ADDR_STATUS, 16'h0001);
            cyc_n(2);
            chk("irq_clr", 0, irq_o);
         end
         while (estart_act_o === 1'b1 && cyc - t0 < 200) cyc_n(1);
         chk("window", 1, cyc - t0 >= ET * TK - TK - 1
             && cyc - t0 <= ET * TK + TK + 1);
         cyc_n(2);
         chk("ext_back", 1, restart_inhib_o);
         chk("temp_off", {1'b0, temp_a_set_i}, temp_a_thr_o);
         cyc_n(20);
         chk("no_retrig", 0, estart_act_o);
         di_i[0] <= 1'b0;
         wr(ADDR_MASK, 16'h0000);
         cyc_n(5);
      end
      stop_test();
   end
endmodule
`default_nettype wire
